// [rtl/lfss_defs.svh]
// Register map, field positions, reset values and timing counts
`ifndef LFSS_DEFS_SVH
`define LFSS_DEFS_SVH

// Register addresses carried in bits 14..8 of the command byte
`define LFSS_ADDR_CONFIG    7'h10
`define LFSS_ADDR_SD_TIMING 7'h11
`define LFSS_ADDR_WK_TIMING 7'h12
`define LFSS_ADDR_GCURRENT  7'h15

// Serial word layout
`define LFSS_WORD_RD_BIT    15
`define LFSS_WORD_ADDR_MSB  14
`define LFSS_WORD_ADDR_LSB  8

// Configuration register fields
`define LFSS_CFG_RUN_BIT    0
`define LFSS_CFG_WAKE_BIT   1
`define LFSS_CFG_RAMP_BIT   2
`define LFSS_CFG_EXT_BIT    3

// Shutdown timing fields
`define LFSS_SD_FADE_LSB    0
`define LFSS_SD_HOLD_LSB    3

// Reset values and DAC end levels
`define LFSS_RST_SD_TIMING  6'h00
`define LFSS_RST_WK_TIMING  3'h0
`define LFSS_RST_GCURRENT   3'h7
`define LFSS_DAC_FULL       3'h7
`define LFSS_DAC_ZERO       3'h0

// Timing: system clock, PWM clock, shortest ramp time of 1/16 s
`define LFSS_CLK_HZ         20000000
`define LFSS_PWM_FREQ_HZ    32768
`define LFSS_INT_DIV        (`LFSS_CLK_HZ / `LFSS_PWM_FREQ_HZ)
`define LFSS_MIN_FRACTION   16
`define LFSS_MIN_TICKS      (`LFSS_PWM_FREQ_HZ / `LFSS_MIN_FRACTION)
`define LFSS_DAC_STEPS      8
`define LFSS_STEP_TICKS     (`LFSS_MIN_TICKS / `LFSS_DAC_STEPS)

`endif

// [rtl/lfss_pkg.sv]
// Types shared by the fade sequencer modules
package lfss_pkg;

   // Sequencer phases, one-hot
   typedef enum logic [4:0] {
      LFSS_RUN  = 5'b00001,
      LFSS_HOLD = 5'b00010,
      LFSS_FADE = 5'b00100,
      LFSS_SHUT = 5'b01000,
      LFSS_RAMP = 5'b10000
   } lfss_phase_type;

   // Serial link state, serial clock domain
   typedef struct packed {
      logic        first;
      logic [15:0] sr;
   } lfss_link_type;

   // PWM tick timer state
   typedef struct packed {
      logic [9:0]  div;
      logic        ext_s1;
      logic        ext_s2;
      logic        ext_s3;
      logic [17:0] cnt;
      logic        done;
   } lfss_timer_type;

   // Sequencer and register state
   typedef struct packed {
      lfss_phase_type st;
      logic           run;
      logic           wake_en;
      logic           ramp_en;
      logic           ext_sel;
      logic [5:0]     sd;
      logic [2:0]     wk;
      logic [2:0]     gcur;
      logic [2:0]     dac;
      logic [2:0]     scale;
      logic           shut;
      logic           osc_en;
      logic [15:0]    rd_word;
      logic           cs1;
      logic           cs2;
      logic           cs3;
   } lfss_seq_type;

endpackage : lfss_pkg

// [rtl/lfss_spi_link.sv]
// Serial shift register on the serial clock
`timescale 1ns/1ps
`default_nettype none
module lfss_spi_link
   import lfss_pkg::*;
(
   input  wire logic        rst,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        sdi,
   input  wire logic [15:0] rd_word,
   output logic      [15:0] shift_word,
   output logic             sdo
);

   lfss_link_type q, d;

   ////////////////////////////////////////////////////////////////////////
   // Shift on rising edges; frame starts from the last latched word
   always_comb begin
      d       = q;
      d.first = 1'b0;
      if (q.first) begin
         d.sr = {rd_word[14:0], sdi};
      end else begin
         d.sr = {q.sr[14:0], sdi};
      end
   end

   // Deselect parks the frame; sclk and sdi are ignored while high
   always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
      if (cs_n || rst) begin
         q.first <= 1'b1;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Always driven, never floats, even when deselected
   assign sdo        = q.first ? rd_word[15] : q.sr[15];
   // Stable once cs_n is high; read only after the synced rise
   assign shift_word = q.sr;

endmodule : lfss_spi_link
`default_nettype wire

// [rtl/lfss_tick_timer.sv]
// PWM clock source and tick down-counter for ramp timing
`timescale 1ns/1ps
`default_nettype none
`include "lfss_defs.svh"
module lfss_tick_timer
   import lfss_pkg::*;
#(
   parameter int INT_DIV = `LFSS_INT_DIV
)(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ext_sel,
   input  wire logic        osc_run,
   input  wire logic        external_pwm_clock_input,
   input  wire logic        load,
   input  wire logic [17:0] load_ticks,
   output logic             done
);

   // Divider is ten bits wide and needs at least two states
   if (INT_DIV < 2 || INT_DIV > 1023) begin : g_bad_div
      $error("INT_DIV out of range");
   end

   localparam logic [9:0] DIV_LAST = 10'(INT_DIV - 1);

   lfss_timer_type q, d;
   logic           tick;

   ////////////////////////////////////////////////////////////////////////
   // Tick from external clock edge or internal divider
   assign tick = ext_sel ? (q.ext_s2 & ~q.ext_s3)
                         : (osc_run && q.div == DIV_LAST);

   // All durations are counted in PWM clock ticks
   always_comb begin
      d        = q;
      d.ext_s1 = external_pwm_clock_input;
      d.ext_s2 = q.ext_s1;
      d.ext_s3 = q.ext_s2;
      d.done   = 1'b0;
      // Internal oscillator stops when nobody needs it
      if (osc_run && !ext_sel) begin
         d.div = (q.div == DIV_LAST) ? 10'h000 : q.div + 10'h001;
      end else begin
         d.div = 10'h000;
      end
      // External clock must keep running until the sequence ends
      if (load) begin
         d.cnt = load_ticks;
      end else if (tick && q.cnt != 18'h00000) begin
         d.cnt  = q.cnt - 18'h00001;
         d.done = (q.cnt == 18'h00001);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;

endmodule : lfss_tick_timer
`default_nettype wire

// [rtl/lfss_sequencer.sv]
// Shutdown fade sequencer with serial register access
// Operation
// - Fade code bits 2..0 at 0x11: 0 instant, else 1/16 s doubling to 4 s
// - Hold code bits 5..3 at 0x11: 0 none, else 1/16 s doubling to 4 s
// - Reading 0x11 returns zeros in bits 7..6, stored codes below
// - Wake code at 0x12: 0 instant full current, else timed ramp-up
// - All ramp durations are counted in PWM clock ticks at 32768 Hz
// - Unless the external clock is selected, the internal oscillator runs throughout a fade even without PWM ports
// - Ramps step a 3-bit DAC scaling the master current reference
// - Global current setting caps the DAC during both ramps
// - Configuration register shows hold, fade and ramp-up status bits
// - One configuration write starts shutdown and sets wake options
// - Data shifts only with chip select low, sampled on rising sclk
// - Serial output is always driven and valid at rising sclk
// - Serial clock and data are ignored while chip select is high
// - Each transaction is 16 bits: command byte then data byte
// - Hold-off keeps full programmed current; reduction waits for fade
// - Bit 15 high reads, low writes; bits 14..8 address
// - Chip select rise latches the last 16 bits shifted
`timescale 1ns/1ps
`default_nettype none
`include "lfss_defs.svh"
module lfss_sequencer
   import lfss_pkg::*;
#(
   parameter int INT_DIV = `LFSS_INT_DIV
)(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       sdi,
   output logic            sdo,
   input  wire logic       external_pwm_clock_input,
   input  wire logic       pwm_ports_active,
   output logic      [2:0] current_scale,
   output logic            shutdown,
   output logic            internal_osc_enable
);

   lfss_seq_type   q, d;
   logic [15:0]    shift_word;
   logic           t_load;
   logic [17:0]    t_ticks;
   logic           t_done;
   logic           frame_done;
   logic           is_rd;
   logic [6:0]     addr;
   logic [7:0]     wdata;
   logic           wr_cfg;
   logic [7:0]     rdata;
   logic [2:0]     hold_code;
   logic [2:0]     fade_code;

   // Code n gives base << (n-1) ticks; code 0 is loaded only when rewritten mid-phase
   function automatic logic [17:0] code_ticks(input logic [2:0] code,
                                              input logic [17:0] base);
      logic [2:0] sh;
      sh = code - 3'h1;
      return base << sh;
   endfunction : code_ticks

   localparam logic [17:0] HOLD_BASE = 18'(`LFSS_MIN_TICKS);
   localparam logic [17:0] STEP_BASE = 18'(`LFSS_STEP_TICKS);

   ////////////////////////////////////////////////////////////////////////
   // Serial link and tick timer
   lfss_spi_link u_link (
      .rst        (rst),
      .sclk       (sclk),
      .cs_n       (cs_n),
      .sdi        (sdi),
      .rd_word    (q.rd_word),
      .shift_word (shift_word),
      .sdo        (sdo)
   );

   lfss_tick_timer #(
      .INT_DIV (INT_DIV)
   ) u_timer (
      .clk                      (clk),
      .rst                      (rst),
      .ext_sel                  (q.ext_sel),
      .osc_run                  (q.osc_en),
      .external_pwm_clock_input (external_pwm_clock_input),
      .load                     (t_load),
      .load_ticks               (t_ticks),
      .done                     (t_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Word decode; the shift word is quiet once the synced cs rise arrives
   assign frame_done = q.cs2 & ~q.cs3;
   assign is_rd      = shift_word[`LFSS_WORD_RD_BIT];
   assign addr       = shift_word[`LFSS_WORD_ADDR_MSB:`LFSS_WORD_ADDR_LSB];
   assign wdata      = shift_word[7:0];
   assign wr_cfg     = frame_done && !is_rd && addr == `LFSS_ADDR_CONFIG;
   assign hold_code  = q.sd[`LFSS_SD_HOLD_LSB +: 3];
   assign fade_code  = q.sd[`LFSS_SD_FADE_LSB +: 3];

   // Read mux; status bits are read-only
   always_comb begin
      case (addr)
         `LFSS_ADDR_CONFIG:
            rdata = {q.st == LFSS_RAMP, q.st == LFSS_FADE,
                     q.st == LFSS_HOLD, 1'b0, q.ext_sel, q.ramp_en,
                     q.wake_en, q.run};
         `LFSS_ADDR_SD_TIMING: rdata = {2'b00, q.sd};
         `LFSS_ADDR_WK_TIMING: rdata = {5'h00, q.wk};
         `LFSS_ADDR_GCURRENT:  rdata = {5'h00, q.gcur};
         default:              rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers, phase machine and DAC
   always_comb begin
      d       = q;
      d.cs1   = cs_n;
      d.cs2   = q.cs1;
      d.cs3   = q.cs2;
      t_load  = 1'b0;
      t_ticks = 18'h00000;
      // Frame end: reads replace the data byte, writes update registers
      if (frame_done) begin
         if (is_rd) begin
            d.rd_word = {shift_word[15:8], rdata};
         end else begin
            d.rd_word = shift_word;
            case (addr)
               `LFSS_ADDR_CONFIG: begin
                  d.run     = wdata[`LFSS_CFG_RUN_BIT];
                  d.wake_en = wdata[`LFSS_CFG_WAKE_BIT];
                  d.ramp_en = wdata[`LFSS_CFG_RAMP_BIT];
                  d.ext_sel = wdata[`LFSS_CFG_EXT_BIT];
               end
               `LFSS_ADDR_SD_TIMING: d.sd   = wdata[5:0];
               `LFSS_ADDR_WK_TIMING: d.wk   = wdata[2:0];
               `LFSS_ADDR_GCURRENT:  d.gcur = wdata[2:0];
               default: ;
            endcase
         end
      end
      case (q.st)
         LFSS_RUN, LFSS_RAMP: begin
            if (wr_cfg && !wdata[`LFSS_CFG_RUN_BIT]) begin
               // Hold-off keeps the DAC at full scale
               d.dac = `LFSS_DAC_FULL;
               if (hold_code != 3'h0) begin
                  d.st    = LFSS_HOLD;
                  t_load  = 1'b1;
                  t_ticks = code_ticks(hold_code, HOLD_BASE);
               end else if (fade_code != 3'h0) begin
                  d.st    = LFSS_FADE;
                  t_load  = 1'b1;
                  t_ticks = code_ticks(fade_code, STEP_BASE);
               end else begin
                  d.st  = LFSS_SHUT;
                  d.dac = `LFSS_DAC_ZERO;
               end
            end else if (q.st == LFSS_RAMP && t_done) begin
               if (q.dac == `LFSS_DAC_FULL) begin
                  d.st = LFSS_RUN;
               end else begin
                  d.dac   = q.dac + 3'h1;
                  t_load  = 1'b1;
                  t_ticks = code_ticks(q.wk, STEP_BASE);
               end
            end
         end
         LFSS_HOLD, LFSS_FADE: begin
            if (wr_cfg && wdata[`LFSS_CFG_RUN_BIT]) begin
               // Restart during ramp-down returns straight to full
               d.st  = LFSS_RUN;
               d.dac = `LFSS_DAC_FULL;
            end else if (t_done) begin
               if (q.st == LFSS_HOLD && fade_code != 3'h0) begin
                  d.st    = LFSS_FADE;
                  t_load  = 1'b1;
                  t_ticks = code_ticks(fade_code, STEP_BASE);
               end else if (q.st == LFSS_HOLD || q.dac == 3'h0) begin
                  d.st  = LFSS_SHUT;
                  d.dac = `LFSS_DAC_ZERO;
               end else begin
                  d.dac   = q.dac - 3'h1;
                  t_load  = 1'b1;
                  t_ticks = code_ticks(fade_code, STEP_BASE);
               end
            end
         end
         LFSS_SHUT: begin
            // Wake by configuration write or, if armed, by a cs pulse
            if ((wr_cfg && wdata[`LFSS_CFG_RUN_BIT]) ||
                (frame_done && q.wake_en && !wr_cfg)) begin
               d.run = 1'b1;
               if (d.ramp_en && d.wk != 3'h0) begin
                  d.st    = LFSS_RAMP;
                  d.dac   = `LFSS_DAC_ZERO;
                  t_load  = 1'b1;
                  t_ticks = code_ticks(d.wk, STEP_BASE);
               end else begin
                  d.st  = LFSS_RUN;
                  d.dac = `LFSS_DAC_FULL;
               end
            end
         end
         default: begin
            d.st  = LFSS_SHUT;
            d.dac = `LFSS_DAC_ZERO;
         end
      endcase
      // Global current caps the top of both ramps
      d.scale  = (d.dac < d.gcur) ? d.dac : d.gcur;
      d.shut   = (d.st == LFSS_SHUT);
      // Oscillator stays up through a sequence on the internal clock, even with PWM unused
      d.osc_en = !d.ext_sel && (pwm_ports_active ||
                 d.st == LFSS_HOLD || d.st == LFSS_FADE ||
                 d.st == LFSS_RAMP);
   end

   // Comes up in shutdown with cs_n assumed idle high
   always_ff @(posedge clk) begin
      if (rst) begin
         q         <= '0;
         q.st      <= LFSS_SHUT;
         q.sd      <= `LFSS_RST_SD_TIMING;
         q.wk      <= `LFSS_RST_WK_TIMING;
         q.gcur    <= `LFSS_RST_GCURRENT;
         q.shut    <= 1'b1;
         q.cs1     <= 1'b1;
         q.cs2     <= 1'b1;
         q.cs3     <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign current_scale       = q.scale;
   assign shutdown            = q.shut;
   assign internal_osc_enable = q.osc_en;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_sd_read_zero: assert property (frame_done && is_rd &&
      addr == `LFSS_ADDR_SD_TIMING |=> q.rd_word[7:6] == 2'b00 &&
      q.rd_word[5:0] == $past(q.sd))
      else $error("shutdown timing readback wrong");
   a_hold_full_cur: assert property (q.st == LFSS_HOLD &&
      $past(q.st) == LFSS_HOLD |-> q.scale == q.gcur)
      else $error("current reduced during hold-off");
   a_scale_cap: assert property (q.scale <= q.gcur)
      else $error("scale above global current");
   a_status_clear: assert property (q.st == LFSS_SHUT |->
      !rdata[7] && !rdata[6] && !rdata[5] || addr != `LFSS_ADDR_CONFIG)
      else $error("status set in shutdown");
   a_sd_start: assert property (q.st == LFSS_RUN && wr_cfg &&
      !wdata[`LFSS_CFG_RUN_BIT] |=> q.st != LFSS_RUN ##1 q.shut ||
      q.st != LFSS_RUN)
      else $error("shutdown write not taken");
   a_hold_skip: assert property (q.st == LFSS_RUN && wr_cfg &&
      !wdata[`LFSS_CFG_RUN_BIT] && hold_code == 3'h0 |=> q.st != LFSS_HOLD)
      else $error("zero hold-off entered hold");
   a_fade_step: assert property (q.st == LFSS_FADE && t_done &&
      q.dac != 3'h0 && !wr_cfg |=> q.dac == $past(q.dac) - 3'h1)
      else $error("fade step wrong");
   a_fade_zero: assert property (q.st == LFSS_HOLD && t_done &&
      fade_code == 3'h0 && !wr_cfg |=> q.st == LFSS_SHUT ##1 q.shut)
      else $error("instant fade did not shut down");
   a_ramp_end: assert property (q.st == LFSS_RAMP && t_done &&
      q.dac == `LFSS_DAC_FULL && !wr_cfg |=> q.st == LFSS_RUN)
      else $error("ramp-up did not finish");
   a_osc_on: assert property (q.st == LFSS_FADE && !q.ext_sel &&
      $past(q.st) == LFSS_FADE |-> q.osc_en)
      else $error("oscillator off during fade");

   // Ramp-up climbs one step per period; end levels are fixed
   a_ramp_step: assert property (q.st == LFSS_RAMP && t_done &&
      q.dac != `LFSS_DAC_FULL && !wr_cfg |=> q.dac == $past(q.dac) + 3'h1)
      else $error("ramp step wrong");
   a_hold_dac_full: assert property (q.st == LFSS_HOLD |->
      q.dac == `LFSS_DAC_FULL)
      else $error("dac below full in hold-off");
   a_shut_zero: assert property (q.st == LFSS_SHUT |->
      q.shut && q.scale == 3'h0)
      else $error("shutdown level wrong");
   a_wake_full: assert property (q.st == LFSS_SHUT && wr_cfg &&
      wdata[`LFSS_CFG_RUN_BIT] && !wdata[`LFSS_CFG_RAMP_BIT] |=>
      q.st == LFSS_RUN && q.dac == `LFSS_DAC_FULL)
      else $error("instant wake not at full current");

   // Phase ends seen one edge apart, plus a read frame and a cs wake, kept short for the tools
   c_full_fade: cover property (q.st == LFSS_FADE ##1 q.st == LFSS_SHUT);
   c_ramp_up: cover property (q.st == LFSS_RAMP ##1 q.st == LFSS_RUN);
   c_read: cover property (frame_done && is_rd);
   c_hold_abort: cover property (q.st == LFSS_HOLD ##1 q.st == LFSS_RUN);
   c_cs_wake: cover property (q.st == LFSS_SHUT && frame_done && q.wake_en);

endmodule : lfss_sequencer
`default_nettype wire

// [verif/lfss_host_model.sv]
// Host serial master model driving the link pins
`timescale 1ns/1ps
`default_nettype none
module lfss_host_model (
   output logic     sclk,
   output logic     cs_n,
   output logic     sdi,
   input  wire logic sdo
);
   localparam time HALF = 80ns;

   ////////////////////////////////////////////////////////////////////////
   // Idle: clock parked low, deselected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end

   // One frame of n bits, MSB first; returns the bits seen on sdo
   task automatic xfer(input logic [31:0] word, input int n,
                       output logic [15:0] got);
      got = 16'h0000;
      #37;
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi = word[i];
         #HALF;
         got = {got[14:0], sdo};
         sclk = 1'b1;
         #HALF;
         sclk = 1'b0;
      end
      #HALF;
      cs_n = 1'b1;
      // Released data shows the inverse, never a stale bit
      sdi = ~sdi;
      // Gap long enough for the word to be captured
      #300;
   endtask : xfer

   // Traffic for another device while this one is deselected
   task automatic noise(input int n);
      for (int i = 0; i < n; i++) begin
         sdi = ~sdi;
         #HALF;
         sclk = 1'b1;
         #HALF;
         sclk = 1'b0;
      end
   endtask : noise
endmodule : lfss_host_model
`default_nettype wire

// [verif/lfss_sequencer_bench.sv]
// Self-checking bench for the fade shutdown sequencer
`timescale 1ns/1ps
`default_nettype none
module lfss_sequencer_bench;
   typedef struct {
      logic [6:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } lfss_row_type;
   localparam int LIMIT = 60000;
   logic         clk = 1'b0;
   logic         rst;
   logic         ext_clk = 1'b0;
   logic         ext_run = 1'b0;
   logic         pwm_act = 1'b0;
   wire          sclk;
   wire          cs_n;
   wire          sdi;
   wire          sdo;
   logic [2:0]   scale;
   logic         shut;
   logic         osc;
   logic [15:0]  g;
   logic         ok;
   int           n_fail = 0;
   int           n_compared = 0;
   int           cyc = 0;
   int           t0;
   // Write value, then read-back expectation; last rows leave gcur at 3
   lfss_row_type rows [6] = '{'{7'h11, 8'hff, 8'h3f}, '{7'h11, 8'hc9, 8'h09},
      '{7'h12, 8'hff, 8'h07}, '{7'h12, 8'h01, 8'h01},
      '{7'h20, 8'h5a, 8'h00}, '{7'h15, 8'h03, 8'h03}};

   ////////////////////////////////////////////////////////////////////////
   // Short tick divider keeps every ramp within a few thousand cycles
   lfss_sequencer #(.INT_DIV(2)) lfss_sequencer_inst (
      .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
      .external_pwm_clock_input(ext_clk), .pwm_ports_active(pwm_act),
      .current_scale(scale), .shutdown(shut), .internal_osc_enable(osc));
   lfss_host_model lfss_host_model_inst (
      .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

   // System clock
   always #25 clk = ~clk;

   // Cycle count, external PWM clock of four cycles, hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (ext_run && (cyc % 2 == 0)) ext_clk <= ~ext_clk;
      if (cyc == LIMIT) begin
         n_fail++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string s, input logic [15:0] e,
                        input logic [15:0] got);
      n_compared++;
      if (got !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", s, e, got);
      end
   endtask : check

   task automatic clks(input int n);
      repeat (n) @(negedge clk);
   endtask : clks

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      lfss_host_model_inst.xfer({16'h0000, 1'b0, a, d}, 16, g);
   endtask : wr

   // Read takes two frames; the second returns command echo and data
   task automatic rd_chk(input string s, input logic [6:0] a,
                         input logic [7:0] e);
      lfss_host_model_inst.xfer({16'h0000, 1'b1, a, 8'h00}, 16, g);
      lfss_host_model_inst.xfer({16'h0000, 1'b1, a, 8'h00}, 16, g);
      check("echo", {1'b1, a}, g[15:8]);
      check(s, e, g[7:0]);
   endtask : rd_chk

   task automatic finish_test();
      $display("counts: compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      // Raised as an event so the link's asynchronous park sees an edge
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      clks(2);
      check("reset shutdown", 1, shut);
      check("reset scale", 0, scale);
      check("reset osc", 0, osc);
      check("sdo driven", 1, sdo === 1'b0 || sdo === 1'b1);
      rd_chk("reset hold fade", 7'h11, 8'h00);
      rd_chk("reset wake", 7'h12, 8'h00);
      rd_chk("reset gcur", 7'h15, 8'h07);
      rd_chk("reset config", 7'h10, 8'h00);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd_chk("row", rows[i].a, rows[i].e);
      end
      $display("test register table done");
      // Wake with ramp-up, capped by the global current
      wr(7'h10, 8'h05);
      check("wake shutdown", 0, shut);
      rd_chk("ramp status", 7'h10, 8'h85);
      clks(4500);
      check("ramp scale", 3'h3, scale);
      rd_chk("run status", 7'h10, 8'h05);
      $display("test ramp-up done");
      // Hold code 1 then fade code 1, stepping the DAC down from full through eight periods into shutdown
      wr(7'h10, 8'h00);
      t0 = cyc;
      ok = 1'b1;
      rd_chk("hold status", 7'h10, 8'h20);
      while (cyc - t0 < 3900) begin
         ok &= (scale === 3'h3) && (osc === 1'b1) && (shut === 1'b0);
         @(negedge clk);
      end
      check("hold level", 1, ok);
      clks(5000 - (cyc - t0));
      rd_chk("fade status", 7'h10, 8'h40);
      check("fade osc", 1, osc);
      while (shut !== 1'b1 && cyc - t0 < 9000) @(negedge clk);
      check("fade time", 1, cyc - t0 >= 8150 && cyc - t0 <= 8450);
      check("shut scale", 0, scale);
      rd_chk("shut status", 7'h10, 8'h00);
      $display("test shutdown done");
      // Chip-select wake without ramp, then instant shutdown
      wr(7'h11, 8'h00);
      wr(7'h10, 8'h02);
      check("armed shutdown", 1, shut);
      rd_chk("wake frame", 7'h12, 8'h01);
      check("cs wake", 0, shut);
      check("wake scale", 3'h3, scale);
      @(posedge clk);
      pwm_act <= 1'b1;
      clks(3);
      check("osc by ports", 1, osc);
      @(posedge clk);
      pwm_act <= 1'b0;
      wr(7'h10, 8'h00);
      clks(4);
      check("instant shutdown", 1, shut);
      $display("test cs wake done");
      // External PWM clock held still, then run
      wr(7'h11, 8'h08);
      wr(7'h10, 8'h01);
      wr(7'h10, 8'h08);
      clks(5000);
      check("stalled hold", 0, shut);
      rd_chk("ext hold status", 7'h10, 8'h28);
      @(posedge clk);
      ext_run <= 1'b1;
      clks(8500);
      check("ext hold end", 1, shut);
      $display("test external clock done");
      // Short and long frames, traffic while deselected
      lfss_host_model_inst.xfer(32'h0011, 16, g);
      lfss_host_model_inst.noise(6);
      lfss_host_model_inst.xfer(32'h002a, 8, g);
      rd_chk("short frame", 7'h11, 8'h2a);
      lfss_host_model_inst.xfer(32'hff1203, 24, g);
      rd_chk("long frame", 7'h12, 8'h03);
      $display("test link framing done");
      // Restart written during a long hold-off returns to full current
      wr(7'h10, 8'h01);
      wr(7'h10, 8'h00);
      rd_chk("abort hold status", 7'h10, 8'h20);
      wr(7'h10, 8'h01);
      check("abort shutdown", 0, shut);
      check("abort scale", 3'h3, scale);
      rd_chk("abort status", 7'h10, 8'h01);
      $display("test abort done");
      // Reset in mid-run restores the power-up state
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      clks(2);
      check("rerun shutdown", 1, shut);
      check("rerun scale", 0, scale);
      rd_chk("rerun hold fade", 7'h11, 8'h00);
      rd_chk("rerun gcur", 7'h15, 8'h07);
      $display("test mid-run reset done");
      finish_test();
   end
endmodule : lfss_sequencer_bench
`default_nettype wire
